// *** hw/cisp_defs.svh ***
/*
 Constants for the card interface select and power control block.
 Assumes inclusion by the package and the top module only.
*/
`ifndef CISP_DEFS_SVH
`define CISP_DEFS_SVH
`define CISP_DEBOUNCE_MS      8
`define CISP_CLK_KHZ          200000
`define CISP_DEBOUNCE_CYC     (`CISP_DEBOUNCE_MS * `CISP_CLK_KHZ)
`define CISP_OSC_TIMEOUT      64
`define CISP_DIV_W            3
`endif

// *** hw/cisp_pkg.sv ***
/*
 Types for the card interface select and power control block.
 Assumes the defines header is available on the include path.
*/
`include "cisp_defs.svh"
package cisp_pkg;
	typedef enum logic [1:0] {
		CISP_PWR_ACTIVE   = 2'h0,
		CISP_PWR_STANDBY  = 2'h1,
		CISP_PWR_DEEP     = 2'h2
	} cisp_pwr_type;

	typedef enum logic [1:0] {
		CISP_DIV8 = 2'h0,
		CISP_DIV4 = 2'h1,
		CISP_DIV2 = 2'h2,
		CISP_DIV1 = 2'h3
	} cisp_ratio_type;

	// Host configuration lines held inside the device
	typedef struct packed {
		logic card_power_cmd_n;
		logic card_reset_request;
		logic clk_ratio_sel_a;
		logic clk_ratio_sel_b;
		logic supply_high_sel_n;
		logic supply_low_sel_n;
		logic host_io_line;
		logic host_aux_line_a;
		logic host_aux_line_b;
	} cisp_cfg_type;
endpackage

// *** hw/cisp_top.sv ***
/*
 Select, low-power, clock and presence control of a smart card interface.
 Assumes all pins are asynchronous to clk; the oscillator pin is sampled
 as a level; analog supervisors and the card sequencer sit outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cisp_defs.svh"
// How it works
// - Card inactive (power command high) puts the device in standby by default.
// - Standby keeps supervisors running and presence detection working.
// - Inactive card plus both supply selects low enters deep sleep.
// - Deep sleep turns supervisors off; fault flag follows inverted presence input.
// - Crystal oscillator is halted by the device on deep sleep entry.
// - Crystal or external clock is detected automatically, no configuration pin.
// - Crystal runs only while power command is low.
// - Divided card clocks by two, four, eight keep near fifty percent duty.
// - With chip select high all multiplexed lines act normally.
// - Chip select low floats multiplexed pins and freezes configuration.
// - Chip select rise loads pins; power command high starts deactivation.
// - Deselected device shows fault flag high; host polls devices in turn.
// - Removal or fault deactivates card even when deselected; shown after select.
// - Presence input is active low; an open input reads as present.
// - Insertion reported after stable debounce interval; removal acts immediately.
// - Rising edge of internal power command starts deactivation.
module cisp_top
	import cisp_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CYC = `CISP_DEBOUNCE_CYC
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         chip_select,
	input  wire cisp_cfg_type cfg_pins,
	input  wire logic         card_present_n,
	input  wire logic         osc_input,
	input  wire logic         supply_fault,
	input  wire logic         card_io_in,
	output logic              host_io_out,
	output logic              host_io_oe_n,
	output logic              fault_flag_n,
	output logic              fault_flag_oe_n,
	output logic              card_clk,
	output logic              card_power_on,
	output logic              card_rst,
	output logic              deactivate_start,
	output logic              supervisors_on,
	output logic              osc_enable,
	output logic              crystal_mode,
	output cisp_pwr_type      power_state,
	output cisp_cfg_type      cfg_internal
);
	localparam int CFG_W = $bits(cisp_cfg_type);

	// Three-stage synchronisers; a change counts when stages two and three agree
	logic [CFG_W-1:0] cfg_s1;
	logic [CFG_W-1:0] cfg_s2;
	logic [CFG_W-1:0] cfg_s3;
	logic [CFG_W-1:0] cfg_stable;
	logic [2:0]       cs_sync;
	logic [2:0]       pres_sync;
	logic [2:0]       osc_sync;
	logic [2:0]       fault_sync;
	logic             cs_stable;
	logic             pres_stable_n;
	logic             osc_stable;
	logic             fault_stable;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_s1     <= '1;
			cfg_s2     <= '1;
			cfg_s3     <= '1;
		end else begin
			cfg_s1     <= cfg_pins;
			cfg_s2     <= cfg_s1;
			cfg_s3     <= cfg_s2;
		end
	end

	// A single-cycle glitch never reaches stages two and three together
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_sync    <= 3'h0;
			pres_sync  <= 3'h7;
			osc_sync   <= 3'h0;
			fault_sync <= 3'h0;
		end else begin
			cs_sync    <= {cs_sync[1:0], chip_select};
			pres_sync  <= {pres_sync[1:0], card_present_n};
			osc_sync   <= {osc_sync[1:0], osc_input};
			fault_sync <= {fault_sync[1:0], supply_fault};
		end
	end

	wire [CFG_W-1:0] cfg_agree = ~(cfg_s2 ^ cfg_s3);
	wire [CFG_W-1:0] next_cfg_stable = (cfg_s3 & cfg_agree) | (cfg_stable & ~cfg_agree);
	wire next_cs_stable   = (cs_sync[1] == cs_sync[2]) ? cs_sync[2] : cs_stable;
	wire next_pres_stable = (pres_sync[1] == pres_sync[2]) ? pres_sync[2] : pres_stable_n;
	wire next_osc_stable  = (osc_sync[1] == osc_sync[2]) ? osc_sync[2] : osc_stable;
	wire next_fault_stable = (fault_sync[1] == fault_sync[2]) ? fault_sync[2] : fault_stable;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_stable    <= '1;
			cs_stable     <= 1'b0;
			pres_stable_n <= 1'b1;
			osc_stable    <= 1'b0;
			fault_stable  <= 1'b0;
		end else begin
			cfg_stable    <= next_cfg_stable;
			cs_stable     <= next_cs_stable;
			pres_stable_n <= next_pres_stable;
			osc_stable    <= next_osc_stable;
			fault_stable  <= next_fault_stable;
		end
	end

	// Configuration freezes while deselected and reloads on select
	cisp_cfg_type cfg_hold;
	wire cisp_cfg_type next_cfg_hold = cs_stable ? cisp_cfg_type'(cfg_stable) : cfg_hold;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_hold <= '1;
		end else begin
			cfg_hold <= next_cfg_hold;
		end
	end

	// Presence: low is present; open pin pulled low internally reads present
	logic [31:0] deb_count;
	logic        present;
	wire         pres_raw = ~pres_stable_n;
	wire         deb_done = (deb_count >= DEBOUNCE_CYC - 1);
	wire [31:0]  next_deb_count = !pres_raw ? 32'h0 :
		(deb_done ? deb_count : deb_count + 32'h1);
	wire         next_present = pres_raw & (present | deb_done);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			deb_count <= 32'h0;
		end else begin
			deb_count <= next_deb_count;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			present   <= 1'b0;
		end else begin
			present   <= next_present;
		end
	end

	// Power state from frozen configuration
	wire cmd_inactive = cfg_hold.card_power_cmd_n;
	wire deep_req = cmd_inactive & ~cfg_hold.supply_high_sel_n & ~cfg_hold.supply_low_sel_n;
	wire cisp_pwr_type next_power_state = deep_req ? CISP_PWR_DEEP :
		(cmd_inactive ? CISP_PWR_STANDBY : CISP_PWR_ACTIVE);

	// Card session: ends on command rise, removal or fault, even when deselected
	logic cmd_prev_n;
	logic session;
	wire  cmd_rise = cfg_hold.card_power_cmd_n & ~cmd_prev_n;
	wire  fault_evt = session & (~present | fault_stable);
	wire  next_deact = cmd_rise | fault_evt;
	// A session opens only on a fall of the command, never by itself after a fault
	wire  next_session = ~cmd_inactive & present & ~fault_stable & (session | cmd_prev_n);
	logic fault_latched;
	wire  next_fault_latched = fault_evt | (fault_latched & ~cmd_inactive);

	// Crystal detection: no toggling seen on the oscillator pin within a window
	logic [7:0] osc_idle;
	logic       osc_prev;
	wire  osc_edge = osc_stable ^ osc_prev;
	wire  next_osc_enable = (next_power_state == CISP_PWR_ACTIVE);
	wire [7:0] next_osc_idle = osc_edge ? 8'h0 :
		((osc_idle == 8'(`CISP_OSC_TIMEOUT)) ? osc_idle : osc_idle + 8'h1);
	wire  next_crystal = osc_enable ? (osc_idle == 8'(`CISP_OSC_TIMEOUT)) : crystal_mode;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_prev_n       <= 1'b1;
			session          <= 1'b0;
			deactivate_start <= 1'b0;
			fault_latched    <= 1'b0;
		end else begin
			cmd_prev_n       <= cfg_hold.card_power_cmd_n;
			session          <= next_session & ~next_deact;
			deactivate_start <= next_deact;
			fault_latched    <= next_fault_latched;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			power_state      <= CISP_PWR_STANDBY;
		end else begin
			power_state      <= next_power_state;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_enable       <= 1'b0;
			osc_prev         <= 1'b0;
			osc_idle         <= 8'h0;
			crystal_mode     <= 1'b0;
		end else begin
			osc_enable       <= next_osc_enable;
			osc_prev         <= osc_stable;
			osc_idle         <= next_osc_idle;
			crystal_mode     <= next_crystal;
		end
	end

	// Card clock divider; toggling flops give exact half duty for /2,/4,/8
	logic [`CISP_DIV_W-1:0] div_count;
	// Ratio pins are gray coded; the exclusive or turns them into the enum order
	wire cisp_ratio_type ratio = cisp_ratio_type'({cfg_hold.clk_ratio_sel_a,
		cfg_hold.clk_ratio_sel_a ^ cfg_hold.clk_ratio_sel_b});
	wire div_clk = (ratio == CISP_DIV8) ? div_count[2] :
		(ratio == CISP_DIV4) ? div_count[1] :
		(ratio == CISP_DIV2) ? div_count[0] : osc_stable;
	wire next_card_clk = session & div_clk;
	wire [`CISP_DIV_W-1:0] next_div_count = osc_edge & osc_stable ?
		div_count + `CISP_DIV_W'(1) : div_count;

	// Fault flag: deep sleep mirrors inverted presence; deselect shows high
	wire next_fault_flag_n = !cs_stable ? 1'b1 :
		(power_state == CISP_PWR_DEEP) ? ~pres_stable_n : (present & ~fault_latched);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_count       <= '0;
		end else begin
			div_count       <= next_div_count;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			card_clk        <= 1'b0;
		end else begin
			card_clk        <= next_card_clk;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			card_power_on   <= 1'b0;
			card_rst        <= 1'b0;
		end else begin
			card_power_on   <= session;
			card_rst        <= session & cfg_hold.card_reset_request;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			supervisors_on  <= 1'b1;
		end else begin
			supervisors_on  <= (next_power_state != CISP_PWR_DEEP);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_flag_n    <= 1'b1;
			fault_flag_oe_n <= 1'b1;
		end else begin
			fault_flag_n    <= next_fault_flag_n;
			fault_flag_oe_n <= ~cs_stable;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			host_io_out     <= 1'b1;
			host_io_oe_n    <= 1'b1;
		end else begin
			host_io_out     <= card_io_in;
			host_io_oe_n    <= ~(cs_stable & session & cfg_hold.host_io_line);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_internal    <= '1;
		end else begin
			cfg_internal    <= cfg_hold;
		end
	end
endmodule
`default_nettype wire

// *** testbench/cisp_props.sv ***
/* Port checker for cisp_top.
 Assumes the bind below hands on DEBOUNCE_CYC. */
`timescale 1ns/1ps
`default_nettype none
module cisp_props
	import cisp_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CYC = 20
) (
	input wire logic         clk,
	input wire logic         rst_n,
	input wire logic         chip_select,
	input wire logic         card_present_n,
	input wire logic         fault_flag_n,
	input wire logic         fault_flag_oe_n,
	input wire logic         host_io_oe_n,
	input wire logic         deactivate_start,
	input wire logic         supervisors_on,
	input wire logic         osc_enable,
	input wire cisp_pwr_type power_state,
	input wire cisp_cfg_type cfg_internal
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	int unsigned low_cnt;
	wire logic   idle = cfg_internal.card_power_cmd_n;
	wire logic   both_low = !cfg_internal.supply_high_sel_n && !cfg_internal.supply_low_sel_n;
	wire logic   deep = power_state == CISP_PWR_DEEP;
	// Counted at the pin, so the design's sync delay only adds margin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) low_cnt <= 0;
		else low_cnt <= card_present_n ? 0 : low_cnt + 1;
	end
	stby_dflt_a: assert property (idle && !both_low |-> ##[0:2] power_state == CISP_PWR_STANDBY)
		else $error("standby missing");
	deep_entry_a: assert property (idle && both_low |-> ##[0:2] deep)
		else $error("deep sleep missing");
	deep_off_a: assert property (deep |-> ##[0:1] !supervisors_on && !osc_enable)
		else $error("deep sleep left blocks on");
	desel_hiz_a: assert property (!chip_select[*6] |-> fault_flag_oe_n && host_io_oe_n)
		else $error("deselected pin driven");
	desel_frz_a: assert property (!chip_select[*6] |=> $stable(cfg_internal))
		else $error("config moved while deselected");
	deact_edge_a: assert property ($rose(idle) |-> ##[0:2] deactivate_start)
		else $error("no deactivation");
	flag_rem_a: assert property ((chip_select && card_present_n)[*7] |-> !fault_flag_n)
		else $error("removal not flagged");
	deb_hold_a: assert property (chip_select && !deep && !fault_flag_n && low_cnt < DEBOUNCE_CYC / 2
		|=> !fault_flag_n)
		else $error("insertion reported early");
	cover property (deactivate_start);
	cover property (deep);
	cover property ($rose(fault_flag_n));
endmodule
bind cisp_top cisp_props #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_props (.clk, .rst_n, .chip_select,
	.card_present_n, .fault_flag_n, .fault_flag_oe_n, .host_io_oe_n, .deactivate_start,
	.supervisors_on, .osc_enable, .power_state, .cfg_internal);
`default_nettype wire

// *** testbench/cisp_host.sv ***
/* Host controller model: GPIO lines, select and an external clock.
 Assumes the bench calls put and owns a single device select. */
`timescale 1ns/1ps
`default_nettype none
module cisp_host
	import cisp_pkg::*;
(
	input  wire logic  clk,
	output logic       chip_select,
	output cisp_cfg_type cfg_pins,
	output logic       osc_input
);
	logic       run;
	logic [1:0] div;
	initial begin
		chip_select = 1'b0;
		cfg_pins = 9'h1FF;
		osc_input = 1'b0;
		run = 1'b0;
		div = 2'h0;
	end
	// 25 MHz clock that stands still low when stopped
	always @(posedge clk) begin
		div <= div + 2'h1;
		if (div == 2'h3) osc_input <= run ? !osc_input : 1'b0;
	end
	task automatic put(input logic s, input cisp_cfg_type c, input logic r);
		@(posedge clk);
		chip_select <= s;
		cfg_pins <= c;
		run <= r;
	endtask
endmodule
`default_nettype wire

// *** testbench/cisp_test.sv ***
/* Self-checking bench of cisp_top.
 Assumes the checker is bound and the host model drives the lines. */
`timescale 1ns/1ps
`default_nettype none
module test_card_interface_select_power_ctrl;
	import cisp_pkg::*;
	localparam int unsigned DEB = 20;
	localparam cisp_cfg_type IDLE = 9'h1FF;
	localparam cisp_cfg_type DEEP = 9'h1E7;
	localparam cisp_cfg_type ACT[3] = '{9'h09F, 9'h0BF, 9'h0FF};
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	logic         pres_n = 1'b1;
	logic         sel, osc, flag_n, flag_oe_n, io_oe_n, cclk, deact, sup_on, osc_en, xtal, pwr_on;
	cisp_pwr_type pwr;
	cisp_cfg_type pins, cfg;
	int           n_errors = 0;
	int           compares = 0;
	int           cycles = 0;
	always #2.5 clk = ~clk;
	cisp_top #(.DEBOUNCE_CYC(DEB)) dut (.clk, .rst_n, .chip_select(sel), .cfg_pins(pins),
		.card_present_n(pres_n), .osc_input(osc), .supply_fault(1'b0), .card_io_in(1'b1),
		.host_io_out(), .host_io_oe_n(io_oe_n), .fault_flag_n(flag_n), .fault_flag_oe_n(flag_oe_n),
		.card_clk(cclk), .card_power_on(pwr_on), .card_rst(), .deactivate_start(deact),
		.supervisors_on(sup_on), .osc_enable(osc_en), .crystal_mode(xtal), .power_state(pwr),
		.cfg_internal(cfg));
	cisp_host host (.clk, .chip_select(sel), .cfg_pins(pins), .osc_input(osc));
	task automatic wrap_up(input logic hung);
		if (hung) n_errors++;
		if (n_errors == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) wrap_up(1'b1);
	end
	task automatic chk_bit(string what, logic exp, logic got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic chk_cnt(string what, int lo, int hi, int got);
		compares++;
		if (got < lo || got > hi) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask
	// Samples 1 ns after the edge so the design's updates have landed
	task automatic wt(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pres(logic v);
		@(posedge clk);
		pres_n <= v;
	endtask
	task automatic t_presence();
		host.put(1'b1, IDLE, 1'b0);
		wt(10);
		chk_bit("no_card", 1'b0, flag_n);
		pres(1'b0);
		wt(9);
		pres(1'b1);
		pres(1'b1);
		pres(1'b0);
		wt(DEB - 4);
		chk_bit("bounce", 1'b0, flag_n);
		wt(12);
		chk_bit("inserted", 1'b1, flag_n);
		pres(1'b1);
		wt(6);
		chk_bit("removed", 1'b0, flag_n);
		pres(1'b0);
		wt(DEB + 8);
	endtask
	task automatic t_deep();
		host.put(1'b1, DEEP, 1'b0);
		wt(10);
		chk_bit("deep", 1'b1, pwr == CISP_PWR_DEEP);
		chk_bit("sup_off", 1'b0, sup_on);
		chk_bit("osc_off", 1'b0, osc_en);
		pres(1'b1);
		wt(6);
		chk_bit("deep_gone", 1'b0, flag_n);
		pres(1'b0);
		wt(DEB + 10);
		chk_bit("deep_here", 1'b1, flag_n);
		host.put(1'b1, IDLE, 1'b0);
		wt(10);
		chk_bit("wake", 1'b1, pwr == CISP_PWR_STANDBY);
		chk_bit("sup_on", 1'b1, sup_on);
	endtask
	task automatic t_clock();
		int   rises;
		int   high;
		logic last;
		host.put(1'b1, IDLE, 1'b1);
		wt(8);
		for (int i = 0; i < 3; i++) begin
			host.put(1'b1, ACT[i], 1'b1);
			wt(200);
			rises = 0;
			high = 0;
			repeat (512) begin
				last = cclk;
				wt(1);
				rises += int'(cclk && !last);
				high += int'(cclk);
			end
			chk_cnt("card_clk", (8 << i) - 1, (8 << i) + 1, rises);
			chk_cnt("duty", 45, 55, high * 100 / 512);
		end
		chk_bit("ext_clk", 1'b0, xtal);
	endtask
	task automatic t_select();
		logic got;
		host.put(1'b0, ACT[2], 1'b1);
		wt(8);
		host.put(1'b0, IDLE, 1'b1);
		wt(12);
		chk_bit("oe_float", 1'b1, flag_oe_n & io_oe_n);
		chk_bit("frozen", 1'b0, cfg.card_power_cmd_n);
		pres(1'b1);
		wt(10);
		chk_bit("hidden", 1'b1, flag_oe_n);
		chk_bit("auto_off", 1'b0, pwr_on);
		host.put(1'b1, IDLE, 1'b0);
		got = 1'b0;
		repeat (12) begin
			wt(1);
			got |= deact;
		end
		chk_bit("deact", 1'b1, got);
		chk_bit("shown", 1'b0, flag_n | flag_oe_n);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		wt(2);
		chk_bit("standby", 1'b1, pwr == CISP_PWR_STANDBY);
		chk_bit("rst_cfg", 1'b1, cfg == IDLE);
		t_presence();
		t_deep();
		t_clock();
		t_select();
		wrap_up(1'b0);
	end
endmodule
`default_nettype wire
